// ---- ads_consts.vh ----
// Purpose: constants for the alarm display and setpoint access panel
// Assumes: 200 MHz clock
// Notes: register indices are word addresses on the plain register port
`ifndef ADS_CONSTS_VH
`define ADS_CONSTS_VH
////////////////////////////////////////////////////////////////////////////
// Timing
`define ADS_CLK_HZ 32'd200000000
`define ADS_TIMEOUT_S 32'd20
`define ADS_TIMEOUT_CYC (`ADS_TIMEOUT_S * `ADS_CLK_HZ)
`define ADS_BLINK_MS 32'd500
`define ADS_BLINK_CYC (`ADS_BLINK_MS * (`ADS_CLK_HZ / 32'd1000))
`define ADS_SAMPLE_MS 32'd10
`define ADS_SAMPLE_CYC (`ADS_SAMPLE_MS * (`ADS_CLK_HZ / 32'd1000))
////////////////////////////////////////////////////////////////////////////
// Register indices
`define ADS_REG_CTRL 3'h0
`define ADS_REG_CODE 3'h1
`define ADS_REG_SP1 3'h2
`define ADS_REG_SP2 3'h3
`define ADS_REG_BARSEG 3'h4
`define ADS_REG_STATUS 3'h5
// Control fields
`define ADS_CTRL_FLASH 0
`define ADS_CTRL_ACCESS 1
`define ADS_CTRL_BARFMT 2
`define ADS_CTRL_A1LOW 3
`define ADS_CTRL_A2HIGH 4
// Reset values
`define ADS_CTRL_RST 5'h00
`define ADS_CODE_RST 16'h0000
`define ADS_SP_RST 16'h0000
////////////////////////////////////////////////////////////////////////////
// Display item codes
`define ADS_SHOW_VALUE 4'h0
`define ADS_SHOW_TAG1 4'h1
`define ADS_SHOW_TAG2 4'h2
`define ADS_SHOW_ON 4'h3
`define ADS_SHOW_OFF 4'h4
`define ADS_SHOW_ENABLE 4'h5
`define ADS_SHOW_ACCESS_CODE_PROMPT 4'h6
`define ADS_SHOW_CODE 4'h7
`define ADS_SHOW_SP1 4'h8
`define ADS_SHOW_SP2 4'h9
`define ADS_SHOW_EDIT 4'hA
// Bargraph
`define ADS_BAR_SEGS 31
`endif

// ---- ads_buttons.v ----
// Purpose: debounce four push-buttons and report presses
// Assumes: raw buttons synchronous to the clock, active high
// Notes: a press counts once two equal samples agree
`include "ads_consts.vh"
module ads_buttons #(
  parameter [31:0] P_SAMPLE_CYC = `ADS_SAMPLE_CYC
) (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Raw buttons: select, up, down, exit
  input wire [3:0] i_raw,
  // Press pulses and combination pulse
  output reg [3:0] o_press,
  output reg o_combo
);
  reg [31:0] cnt;
  reg [3:0] samp;
  reg [3:0] stable;
  wire tick = (cnt == P_SAMPLE_CYC - 32'd1);
  wire [3:0] next_stable = (samp & i_raw) | (stable & (samp | i_raw));
  wire [3:0] rise = next_stable & ~stable;
  wire both_new = next_stable[0] & next_stable[1] & ~(stable[0] & stable[1]);
  ////////////////////////////////////////////////////////////////////////////
  // Sample tick, two-sample agreement, edge and combination detect
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt <= 32'h0;
      samp <= 4'h0;
      stable <= 4'h0;
      o_press <= 4'h0;
      o_combo <= 1'b0;
    end
    else
    begin
      cnt <= tick ? 32'h0 : cnt + 32'd1;
      o_press <= 4'h0;
      o_combo <= 1'b0;
      if (tick)
      begin
        samp <= i_raw;
        stable <= next_stable;
        if (both_new && rise[0] && rise[1])
        begin
          o_combo <= 1'b1;
          o_press <= rise & 4'hC;
        end
        else
          o_press <= rise;
      end
    end
  end
endmodule // ads_buttons

// ---- ads_panel.v ----
// Purpose: alarm display flashing, direct setpoint access, setpoint bars
// Assumes: alarm evaluation done outside; buttons synchronous
// Notes: register port word indices in ads_consts.vh
// Operation
// - Flash option alternates value with alarm tag
// - Both alarms active show both tags alternately
// - Flash item: on/off shown on entry, up/down change, exit
// - Select plus up opens direct access menu
// - Direct access off ignores the combination
// - Access item: enable prompt, on/off toggle
// - Four digit code edited digit by digit
// - All zero code means no protection
// - Reset: access off, code zero
// - Entry shows setpoint or code prompt first
// - Exit after matching code goes to setpoint
// - Up/down toggles setpoint one and two
// - Wrong code or 20 s idle leaves
// - Select edits setpoint, exit, exit again leaves
// - Bars below low, above high, value bar
// - Value bar flashes next to setpoint region
// - Region flashes when value reaches setpoint
// - Bad alarm setup flashes scale, no bars
// - Tag flashing only while alarm output active
`include "ads_consts.vh"
module ads_panel #(
  parameter [31:0] P_TIMEOUT_CYC = `ADS_TIMEOUT_CYC,
  parameter [31:0] P_BLINK_CYC = `ADS_BLINK_CYC,
  parameter [31:0] P_SAMPLE_CYC = `ADS_SAMPLE_CYC
) (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Register port
  input wire [2:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // Push-buttons
  input wire i_btn_sel,
  input wire i_btn_up,
  input wire i_btn_down,
  input wire i_btn_exit,
  // Alarm state: output active, and value at setpoint
  input wire i_alarm1_out,
  input wire i_alarm2_out,
  input wire i_alarm1_cond,
  input wire i_alarm2_cond,
  // Outer configuration menu hand-over
  input wire i_cfg_enter,
  input wire i_cfg_item,
  output reg o_cfg_done,
  // Displayed value and its bargraph segment
  input wire [15:0] i_value,
  input wire [4:0] i_value_seg,
  // Display
  output reg [3:0] o_disp_item,
  output reg [15:0] o_disp_num,
  output reg [1:0] o_edit_digit,
  output reg [30:0] o_bar,
  output reg o_bar_scale
);
  ////////////////////////////////////////////////////////////////////////////
  // Menu states, one-hot
  localparam [9:0] S_DISP = 10'h001;
  localparam [9:0] S_CF_FLASH = 10'h002;
  localparam [9:0] S_CA_EN = 10'h004;
  localparam [9:0] S_CA_VAL = 10'h008;
  localparam [9:0] S_CA_CODE = 10'h010;
  localparam [9:0] S_CA_EDIT = 10'h020;
  localparam [9:0] S_DA_CODE = 10'h040;
  localparam [9:0] S_DA_EDIT = 10'h080;
  localparam [9:0] S_DA_SP = 10'h100;
  localparam [9:0] S_DA_SPED = 10'h200;

  // Step one BCD digit up or down with wrap
  function [15:0] ads_bcd_step;
    input [15:0] w;
    input [1:0] d;
    input up;
    reg [3:0] n;
    begin
      n = w[d*4 +: 4];
      if (up)
        n = (n >= 4'h9) ? 4'h0 : n + 4'h1;
      else
        n = (n == 4'h0) ? 4'h9 : n - 4'h1;
      ads_bcd_step = w;
      ads_bcd_step[d*4 +: 4] = n;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  reg rst_meta;
  reg rst_n;
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buttons
  wire [3:0] press;
  wire combo;
  ads_buttons #(
    .P_SAMPLE_CYC(P_SAMPLE_CYC)
  ) u_buttons (
    .i_clk(i_clk),
    .i_resetn(rst_n),
    .i_raw({i_btn_exit, i_btn_down, i_btn_up, i_btn_sel}),
    .o_press(press),
    .o_combo(combo)
  );
  wire p_sel = press[0];
  wire p_up = press[1];
  wire p_dn = press[2];
  wire p_ex = press[3];
  wire p_ud = p_up | p_dn;
  wire p_any = (|press) | combo;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and menu state
  reg [9:0] state;
  reg [4:0] ctrl;
  reg [15:0] code;
  reg [15:0] entry;
  reg [15:0] sp1;
  reg [15:0] sp2;
  reg [4:0] lo_seg;
  reg [4:0] hi_seg;
  reg sp_sel;
  reg [1:0] digit;
  reg [31:0] idle;
  wire in_direct = |(state & (S_DA_CODE | S_DA_EDIT | S_DA_SP | S_DA_SPED));
  wire idle_out = in_direct && (idle == P_TIMEOUT_CYC - 32'd1);
  wire cfg_bad = !ctrl[`ADS_CTRL_A1LOW] || !ctrl[`ADS_CTRL_A2HIGH] ||
    (sp1 >= sp2);

  // Inactivity counter for the direct access menu
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      idle <= 32'h0;
    else if (!in_direct || p_any)
      idle <= 32'h0;
    else
      idle <= idle + 32'd1;
  end

  // Menu walk, register writes and read data
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_DISP;
      ctrl <= `ADS_CTRL_RST;
      code <= `ADS_CODE_RST;
      entry <= 16'h0000;
      sp1 <= `ADS_SP_RST;
      sp2 <= `ADS_SP_RST;
      lo_seg <= 5'h00;
      hi_seg <= 5'h1E;
      sp_sel <= 1'b0;
      digit <= 2'h3;
      o_cfg_done <= 1'b0;
      o_rdata <= 16'h0000;
    end
    else
    begin
      o_cfg_done <= 1'b0;
      case (state)
        S_DISP:
        begin
          if (combo && ctrl[`ADS_CTRL_ACCESS])
          begin
            sp_sel <= 1'b0;
            state <= (code == 16'h0000) ? S_DA_SP : S_DA_CODE;
          end
          else if (i_cfg_enter)
            state <= i_cfg_item ? S_CA_EN : S_CF_FLASH;
        end
        S_CF_FLASH:
        begin
          if (p_ud)
            ctrl[`ADS_CTRL_FLASH] <= ~ctrl[`ADS_CTRL_FLASH];
          else if (p_ex)
          begin
            state <= S_DISP;
            o_cfg_done <= 1'b1;
          end
        end
        S_CA_EN:
        begin
          if (p_sel)
            state <= S_CA_VAL;
          else if (p_ud)
            state <= S_CA_CODE;
          else if (p_ex)
          begin
            state <= S_DISP;
            o_cfg_done <= 1'b1;
          end
        end
        S_CA_VAL:
        begin
          if (p_ud)
            ctrl[`ADS_CTRL_ACCESS] <= ~ctrl[`ADS_CTRL_ACCESS];
          else if (p_sel || p_ex)
            state <= S_CA_EN;
        end
        S_CA_CODE:
        begin
          if (p_sel)
          begin
            digit <= 2'h3;
            state <= S_CA_EDIT;
          end
          else if (p_ud)
            state <= S_CA_EN;
          else if (p_ex)
          begin
            state <= S_DISP;
            o_cfg_done <= 1'b1;
          end
        end
        S_CA_EDIT:
        begin
          if (p_ud)
            code <= ads_bcd_step(code, digit, p_up);
          else if (p_sel)
            digit <= digit - 2'h1;
          else if (p_ex)
            state <= S_CA_CODE;
        end
        S_DA_CODE:
        begin
          if (p_sel)
          begin
            entry <= 16'h0000;
            digit <= 2'h3;
            state <= S_DA_EDIT;
          end
          else if (p_ex || idle_out)
            state <= S_DISP;
        end
        S_DA_EDIT:
        begin
          if (idle_out)
            state <= S_DISP;
          else if (p_ud)
            entry <= ads_bcd_step(entry, digit, p_up);
          else if (p_sel)
            digit <= digit - 2'h1;
          else if (p_ex)
            state <= (entry == code) ? S_DA_SP : S_DISP;
        end
        S_DA_SP:
        begin
          if (idle_out)
            state <= S_DISP;
          else if (p_ud)
            sp_sel <= ~sp_sel;
          else if (p_sel)
          begin
            digit <= 2'h3;
            state <= S_DA_SPED;
          end
          else if (p_ex)
            state <= S_DISP;
        end
        S_DA_SPED:
        begin
          if (idle_out)
            state <= S_DISP;
          else if (p_ud && !sp_sel)
            sp1 <= ads_bcd_step(sp1, digit, p_up);
          else if (p_ud)
            sp2 <= ads_bcd_step(sp2, digit, p_up);
          else if (p_sel)
            digit <= digit - 2'h1;
          else if (p_ex)
            state <= S_DA_SP;
        end
        default:
          state <= S_DISP;
      endcase
      // Software writes take precedence over a panel change
      if (i_wr)
      begin
        case (i_addr)
          `ADS_REG_CTRL: ctrl <= i_wdata[4:0];
          `ADS_REG_CODE: code <= i_wdata;
          `ADS_REG_SP1: sp1 <= i_wdata;
          `ADS_REG_SP2: sp2 <= i_wdata;
          `ADS_REG_BARSEG:
          begin
            lo_seg <= i_wdata[4:0];
            hi_seg <= i_wdata[12:8];
          end
          default: ;
        endcase
      end
      // Read data stand only in the cycle after the strobe
      o_rdata <= 16'h0000;
      if (i_rd)
      begin
        case (i_addr)
          `ADS_REG_CTRL: o_rdata <= {11'h000, ctrl};
          `ADS_REG_CODE: o_rdata <= code;
          `ADS_REG_SP1: o_rdata <= sp1;
          `ADS_REG_SP2: o_rdata <= sp2;
          `ADS_REG_BARSEG: o_rdata <= {3'h0, hi_seg, 3'h0, lo_seg};
          `ADS_REG_STATUS: o_rdata <= {4'h0, cfg_bad, sp_sel, state};
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink timer and tag sequence
  reg [31:0] blink_cnt;
  reg [1:0] seq;
  wire blink = seq[0];
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blink_cnt <= 32'h0;
      seq <= 2'h0;
    end
    else if (blink_cnt == P_BLINK_CYC - 32'd1)
    begin
      blink_cnt <= 32'h0;
      seq <= seq + 2'h1;
    end
    else
      blink_cnt <= blink_cnt + 32'd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display selection
  reg [3:0] next_item;
  reg [15:0] next_num;
  always @*
  begin
    next_item = `ADS_SHOW_VALUE;
    next_num = i_value;
    case (state)
      S_DISP:
      begin
        // Flash runs from the active outputs only
        if (ctrl[`ADS_CTRL_FLASH] && blink)
        begin
          if (i_alarm1_out && i_alarm2_out)
            next_item = seq[1] ? `ADS_SHOW_TAG2 : `ADS_SHOW_TAG1;
          else if (i_alarm1_out)
            next_item = `ADS_SHOW_TAG1;
          else if (i_alarm2_out)
            next_item = `ADS_SHOW_TAG2;
        end
      end
      S_CF_FLASH:
        next_item = ctrl[`ADS_CTRL_FLASH] ? `ADS_SHOW_ON : `ADS_SHOW_OFF;
      S_CA_EN:
        next_item = `ADS_SHOW_ENABLE;
      S_CA_VAL:
        next_item = ctrl[`ADS_CTRL_ACCESS] ? `ADS_SHOW_ON : `ADS_SHOW_OFF;
      S_CA_CODE:
        next_item = `ADS_SHOW_ACCESS_CODE_PROMPT;
      S_CA_EDIT:
      begin
        next_item = `ADS_SHOW_EDIT;
        next_num = code;
      end
      S_DA_CODE:
        next_item = `ADS_SHOW_CODE;
      S_DA_EDIT:
      begin
        next_item = `ADS_SHOW_EDIT;
        next_num = entry;
      end
      S_DA_SP:
        next_item = sp_sel ? `ADS_SHOW_SP2 : `ADS_SHOW_SP1;
      S_DA_SPED:
      begin
        next_item = `ADS_SHOW_EDIT;
        next_num = sp_sel ? sp2 : sp1;
      end
      default:
        next_item = `ADS_SHOW_VALUE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint bargraph
  reg [30:0] next_bar;
  reg next_scale;
  reg [4:0] k;
  integer i;
  wire near_sp = (i_value_seg <= lo_seg) || (i_value_seg >= hi_seg);
  always @*
  begin
    next_bar = 31'h0;
    next_scale = 1'b1;
    k = 5'h00;
    if (ctrl[`ADS_CTRL_BARFMT])
    begin
      if (cfg_bad)
        next_scale = ~blink;
      else
      begin
        for (i = 0; i < `ADS_BAR_SEGS; i = i + 1)
        begin
          k = i[4:0];
          if (k < lo_seg)
            next_bar[i] = ~(i_alarm1_cond && blink);
          else if (k > hi_seg)
            next_bar[i] = ~(i_alarm2_cond && blink);
          else if (k == i_value_seg)
            next_bar[i] = ~(near_sp && blink);
        end
      end
    end
  end

  // Display registers
  always @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_disp_item <= `ADS_SHOW_VALUE;
      o_disp_num <= 16'h0000;
      o_edit_digit <= 2'h3;
      o_bar <= 31'h0;
      o_bar_scale <= 1'b0;
    end
    else
    begin
      o_disp_item <= next_item;
      o_disp_num <= next_num;
      o_edit_digit <= digit;
      o_bar <= next_bar;
      o_bar_scale <= next_scale;
    end
  end
endmodule // ads_panel

// ---- ads_operator.sv ----
// Purpose: operator model pressing the four panel buttons
// Assumes: sample tick of four cycles in the panel
// Notes: mask bits are select, up, down, exit from bit 0
module ads_operator (
  // Clock
  input wire i_clk,
  // Buttons, high while pressed
  output logic [3:0] o_btn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_btn = 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Hold for three sample ticks so debounce settles, then release as long
  task automatic press(input logic [3:0] m);
    @(posedge i_clk);
    o_btn <= m;
    repeat (12) @(posedge i_clk);
    o_btn <= 4'h0;
    repeat (12) @(posedge i_clk);
  endtask
endmodule // ads_operator

// ---- ads_monitor.sv ----
// Purpose: port checker for the alarm display panel
// Assumes: counts handed on from the bound panel
// Notes: access bit tracked from bus writes only
`include "ads_consts.vh"
module ads_monitor #(
  parameter [31:0] P_TIMEOUT_CYC = 32'd2000,
  parameter [31:0] P_SAMPLE_CYC = 32'd4
) (
  // Clock, reset and register port
  input wire i_clk,
  input wire i_resetn,
  input wire [2:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  // Buttons, alarms and value
  input wire i_btn_sel,
  input wire i_btn_up,
  input wire i_btn_down,
  input wire i_btn_exit,
  input wire i_alarm1_out,
  input wire i_alarm2_out,
  input wire [15:0] i_value,
  // Display
  input wire o_cfg_done,
  input wire [3:0] o_disp_item,
  input wire [15:0] o_disp_num,
  input wire [30:0] o_bar,
  input wire o_bar_scale
);
  timeunit 1ns;
  timeprecision 1ps;
  logic acc_m;
  logic [2:0] age;
  logic [31:0] idle;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Access bit, cycles since reset, cycles with no button held
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      acc_m <= 1'b0;
      age <= 3'h0;
      idle <= 32'h0;
    end
    else
    begin
      if (i_wr && i_addr == `ADS_REG_CTRL)
        acc_m <= i_wdata[`ADS_CTRL_ACCESS];
      if (age != 3'h7)
        age <= age + 3'h1;
      if (i_btn_sel || i_btn_up || i_btn_down || i_btn_exit)
        idle <= 32'h0;
      else if (idle != 32'hFFFFFFFF)
        idle <= idle + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_rdata_reserved:
    assert property ($past(i_rd) && $past(i_addr) >= 3'h6 |-> o_rdata == 0)
    else $error("reserved index read nonzero");
  a_reset_display:
    assert property (age < 3'h4 |-> o_disp_item == `ADS_SHOW_VALUE &&
      o_bar == 31'h0 && !o_cfg_done)
    else $error("panel not idle after reset");
  a_combo_off:
    assert property (age == 3'h7 && !acc_m && o_disp_item == 4'h0 |=>
      o_disp_item != `ADS_SHOW_CODE && o_disp_item != `ADS_SHOW_SP1)
    else $error("direct access opened while disabled");
  a_idle_leave:
    assert property (idle > P_TIMEOUT_CYC + 4 * P_SAMPLE_CYC + 32'd8 |->
      !(o_disp_item inside {`ADS_SHOW_CODE, `ADS_SHOW_SP1, `ADS_SHOW_SP2}))
    else $error("direct menu kept past idle limit");
  a_tag1_cause:
    assert property (o_disp_item == `ADS_SHOW_TAG1 |-> $past(i_alarm1_out)
      || $past(i_alarm1_out, 2) || $past(i_alarm1_out, 3))
    else $error("alarm one tag without active output");
  a_tag2_cause:
    assert property (o_disp_item == `ADS_SHOW_TAG2 |-> $past(i_alarm2_out)
      || $past(i_alarm2_out, 2) || $past(i_alarm2_out, 3))
    else $error("alarm two tag without active output");
  a_value_shown:
    assert property (age == 3'h7 && o_disp_item == 4'h0 &&
      $past(o_disp_item) == 4'h0 && $stable(i_value) |-> o_disp_num == i_value)
    else $error("displayed number differs from value");
  a_bad_no_bars:
    assert property (age == 3'h7 && !o_bar_scale |-> o_bar == 31'h0)
    else $error("bars lit while scale flashes");
  a_done_pulse:
    assert property (o_cfg_done |=> !o_cfg_done)
    else $error("config done longer than one cycle");
endmodule // ads_monitor
bind ads_panel ads_monitor #(
  .P_TIMEOUT_CYC(P_TIMEOUT_CYC),
  .P_SAMPLE_CYC(P_SAMPLE_CYC)
) u_mon (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_btn_sel(i_btn_sel),
  .i_btn_up(i_btn_up), .i_btn_down(i_btn_down), .i_btn_exit(i_btn_exit),
  .i_alarm1_out(i_alarm1_out), .i_alarm2_out(i_alarm2_out),
  .i_value(i_value), .o_cfg_done(o_cfg_done), .o_disp_item(o_disp_item),
  .o_disp_num(o_disp_num), .o_bar(o_bar), .o_bar_scale(o_bar_scale)
);

// ---- alarm_display_setpoint_access_test.sv ----
// Purpose: self-checking bench for the alarm display panel
// Assumes: shortened timeout, blink and sample counts
// Notes: buttons come from the operator model
`include "ads_consts.vh"
`define ADS_CHK(n, e, a) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) \
    begin \
      miscompares++; \
      $display("Error %s expected %0h seen %0h", n, e, a); \
    end \
  end
module alarm_display_setpoint_access_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic a1o = 1'b0, a2o = 1'b0, a1c = 1'b0, cfg_en = 1'b0, cfg_it = 1'b0;
  logic a2c = 1'b0;
  logic [15:0] val = 16'h0042;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000, rdata, num;
  logic [4:0] vseg = 5'h0A;
  logic [3:0] item;
  logic [5:0] seen;
  logic [1:0] dig;
  logic [30:0] bar;
  logic scale, done;
  wire [3:0] btn;
  int miscompares, cmp_count, cycles, done_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // Clock, run limit and done pulse count
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (done === 1'b1)
      done_cnt++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end
  ads_panel #(
    .P_TIMEOUT_CYC(32'd2000),
    .P_BLINK_CYC(32'd8),
    .P_SAMPLE_CYC(32'd4)
  ) dut (
    .i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_btn_sel(btn[0]),
    .i_btn_up(btn[1]), .i_btn_down(btn[2]), .i_btn_exit(btn[3]),
    .i_alarm1_out(a1o), .i_alarm2_out(a2o), .i_alarm1_cond(a1c),
    .i_alarm2_cond(a2c), .i_cfg_enter(cfg_en), .i_cfg_item(cfg_it),
    .o_cfg_done(done), .i_value(val), .i_value_seg(vseg),
    .o_disp_item(item), .o_disp_num(num), .o_edit_digit(dig), .o_bar(bar),
    .o_bar_scale(scale)
  );
  ads_operator op (.i_clk(clk), .o_btn(btn));
  ////////////////////////////////////////////////////////////////////////////
  // Bus, button and menu helpers
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `ADS_CHK("rdata", e, rdata)
  endtask
  task automatic key(input logic [3:0] m, input logic [3:0] e);
    op.press(m);
    @(negedge clk);
    `ADS_CHK("item", e, item)
  endtask
  task automatic wait_item(input logic [3:0] e);
    int n;
    n = 0;
    while (item !== e && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    `ADS_CHK("item", e, item)
    // Hand back on a rising edge so the next drive follows it
    @(posedge clk);
  endtask
  task automatic cfg_open(input logic it);
    @(posedge clk);
    cfg_it <= it;
    cfg_en <= 1'b1;
    @(posedge clk);
    cfg_en <= 1'b0;
  endtask
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk_reg(`ADS_REG_CTRL, 16'h0000);
    chk_reg(`ADS_REG_CODE, 16'h0000);
    chk_reg(3'h6, 16'h0000);
    key(4'h3, `ADS_SHOW_VALUE);
    wr_reg(`ADS_REG_CTRL, 16'h0002);
    key(4'h3, `ADS_SHOW_SP1);
    key(4'h4, `ADS_SHOW_SP2);
    key(4'h1, `ADS_SHOW_EDIT);
    key(4'h8, `ADS_SHOW_SP2);
    key(4'h8, `ADS_SHOW_VALUE);
    wr_reg(`ADS_REG_CODE, 16'h1234);
    key(4'h3, `ADS_SHOW_CODE);
    op.press(4'h1);
    for (int i = 0; i < 4; i++)
    begin
      repeat (i + 1) op.press(4'h2);
      @(negedge clk);
      `ADS_CHK("digit", 2'(3 - i), dig)
      op.press(4'h1);
    end
    @(negedge clk);
    `ADS_CHK("entry", 16'h1234, num)
    key(4'h8, `ADS_SHOW_SP1);
    key(4'h8, `ADS_SHOW_VALUE);
    key(4'h3, `ADS_SHOW_CODE);
    op.press(4'h1);
    key(4'h8, `ADS_SHOW_VALUE);
    key(4'h3, `ADS_SHOW_CODE);
    repeat (2100) @(posedge clk);
    wait_item(`ADS_SHOW_VALUE);
    // Flashing: condition alone, then one and both outputs active
    wr_reg(`ADS_REG_CTRL, 16'h0003);
    a1c <= 1'b1;
    seen = 6'h00;
    repeat (40)
    begin
      @(negedge clk);
      seen[0] = seen[0] | (item === `ADS_SHOW_TAG1);
    end
    `ADS_CHK("tag", 6'h00, seen)
    @(posedge clk);
    a1o <= 1'b1;
    wait_item(`ADS_SHOW_TAG1);
    a2o <= 1'b1;
    wait_item(`ADS_SHOW_TAG2);
    a1o <= 1'b0;
    a2o <= 1'b0;
    a1c <= 1'b0;
    wait_item(`ADS_SHOW_VALUE);
    val <= 16'h0987;
    repeat (2) @(negedge clk);
    `ADS_CHK("value", 16'h0987, num)
    // Configuration items: flash, then direct access
    cfg_open(1'b0);
    key(4'h1, `ADS_SHOW_ON);
    key(4'h2, `ADS_SHOW_OFF);
    op.press(4'h8);
    cfg_open(1'b1);
    wait_item(`ADS_SHOW_ENABLE);
    key(4'h1, `ADS_SHOW_ON);
    key(4'h4, `ADS_SHOW_OFF);
    key(4'h8, `ADS_SHOW_ENABLE);
    op.press(4'h8);
    `ADS_CHK("done", 2, done_cnt)
    chk_reg(`ADS_REG_CTRL, 16'h0000);
    // Setpoint bargraph: good setup, blinking, bad setup
    wr_reg(`ADS_REG_SP1, 16'h0100);
    wr_reg(`ADS_REG_SP2, 16'h0200);
    wr_reg(`ADS_REG_BARSEG, 16'h1405);
    wr_reg(`ADS_REG_CTRL, 16'h001C);
    repeat (3) @(negedge clk);
    `ADS_CHK("bar", 31'h7FE0041F, bar)
    @(posedge clk);
    vseg <= 5'h05;
    a1c <= 1'b1;
    a2c <= 1'b1;
    seen = 6'h00;
    repeat (40)
    begin
      @(negedge clk);
      seen = seen | {bar[30] === 1'b1, bar[30] === 1'b0,
        bar[5] === 1'b1, bar[5] === 1'b0, bar[0] === 1'b1, bar[0] === 1'b0};
    end
    `ADS_CHK("blink", 6'h3F, seen)
    @(posedge clk);
    a1c <= 1'b0;
    a2c <= 1'b0;
    wr_reg(`ADS_REG_SP2, 16'h0100);
    repeat (3) @(negedge clk);
    `ADS_CHK("bar", 31'h0, bar)
    // Bad setup: the scale must toggle while no bar is lit
    seen = 6'h00;
    repeat (20)
    begin
      @(negedge clk);
      seen = seen | {4'h0, scale === 1'b1, scale === 1'b0};
    end
    `ADS_CHK("scale", 6'h03, seen)
    finish_test();
  end
endmodule // alarm_display_setpoint_access_test
